// ### hdl/dsos_pkg.sv
package dsos_pkg;

  // clock and control sampling period
  localparam int unsigned CLK_PERIOD_NS    = 10;
  localparam int unsigned SAMPLE_PERIOD_NS = 1000;
  localparam int unsigned SAMPLE_CYCLES    = (SAMPLE_PERIOD_NS / CLK_PERIOD_NS < 1) ? 1 :
                                             SAMPLE_PERIOD_NS / CLK_PERIOD_NS;

  localparam int unsigned NUM_FLAGS = 7;
  localparam int unsigned NUM_TERM  = 6;
  localparam int unsigned CUR_W     = 10;

  // flag positions inside the flag vector
  localparam int unsigned FLAG_CMD = 0;
  localparam int unsigned FLAG_OHF = 1;
  localparam int unsigned FLAG_LOC = 2;
  localparam int unsigned FLAG_RDY = 3;
  localparam int unsigned FLAG_FWR = 4;
  localparam int unsigned FLAG_RVR = 5;
  localparam int unsigned FLAG_MJA = 6;

  // terminal selection codes (41, 42, 43, 50, 51, 52, 53)
  localparam logic [7:0] CODE_CMD = 8'h29;
  localparam logic [7:0] CODE_OHF = 8'h2a;
  localparam logic [7:0] CODE_LOC = 8'h2b;
  localparam logic [7:0] CODE_RDY = 8'h32;
  localparam logic [7:0] CODE_FWR = 8'h33;
  localparam logic [7:0] CODE_RVR = 8'h34;
  localparam logic [7:0] CODE_MJA = 8'h35;

  // setting limits: 200 degC, 1.50 x rated in hundredths
  localparam logic [7:0] OHF_THRESH_MAX = 8'hc8;
  localparam logic [7:0] LOC_LEVEL_MAX  = 8'h96;
  localparam logic [1:0] LOC_MODE_RUN   = 2'h0;
  localparam logic [1:0] LOC_MODE_CONST = 2'h1;

  // hardware trip numbers that raise the major-failure flag
  localparam logic [7:0] TRIP_CT      = 8'h0a;
  localparam logic [7:0] TRIP_CPU     = 8'h0b;
  localparam logic [7:0] TRIP_GND     = 8'h0e;
  localparam logic [7:0] TRIP_FAN     = 8'h14;
  localparam logic [7:0] TRIP_GA_COMM = 8'h17;
  localparam logic [7:0] TRIP_MAIN    = 8'h19;

  // register byte offsets
  localparam logic [7:0] OFF_OHF_THRESH = 8'h00;
  localparam logic [7:0] OFF_LOC_MODE   = 8'h04;
  localparam logic [7:0] OFF_LOC_LEVEL  = 8'h08;
  localparam logic [7:0] OFF_TERM_SEL0  = 8'h0c;
  localparam logic [7:0] OFF_SEL_SPAN   = 8'h18;
  localparam logic [7:0] OFF_FLAGS      = 8'h24;
  localparam logic [7:0] OFF_IRQ_STATUS = 8'h28;
  localparam logic [7:0] OFF_IRQ_MASK   = 8'h2c;
  localparam logic [7:0] OFF_RUN_STATE  = 8'h30;

  // reset values
  localparam logic [7:0] RST_OHF_THRESH = 8'h78;
  localparam logic [7:0] RST_LOC_LEVEL  = 8'h00;
  localparam logic [7:0] RST_SEL_TERM0  = 8'h29;
  localparam logic [7:0] RST_SEL_TERM1  = 8'h2a;
  localparam logic [7:0] RST_SEL_TERM2  = 8'h2b;
  localparam logic [7:0] RST_SEL_TERM3  = 8'h32;
  localparam logic [7:0] RST_SEL_TERM4  = 8'h33;
  localparam logic [7:0] RST_SEL_RELAY  = 8'h35;

  typedef enum logic [1:0] {RUN_STOP, RUN_FWD, RUN_REV} dsos_run_state_t;

endpackage

// ### hdl/dsos_flag_eval.sv
`timescale 1ns/1ns
module dsos_flag_eval (
  input  wire logic                          clk_in,
  input  wire logic                          rst_in,
  input  wire logic                          sample_tick_in,
  input  wire logic                          command_present_in,
  input  wire logic [7:0]                    heatsink_temp_in,
  input  wire logic [7:0]                    overheat_threshold_in,
  input  wire logic [dsos_pkg::CUR_W-1:0]    output_current_in,
  input  wire logic [7:0]                    low_current_level_in,
  input  wire logic [1:0]                    low_current_mode_in,
  input  wire logic                          operating_in,
  input  wire logic                          constant_speed_in,
  input  wire logic                          ready_in,
  input  wire logic                          forward_drive_in,
  input  wire logic                          reverse_drive_in,
  input  wire logic                          trip_active_in,
  input  wire logic [7:0]                    trip_code_in,
  output logic      [dsos_pkg::NUM_FLAGS-1:0] flags_out
);
  import dsos_pkg::*;

  wire                 low_current   = output_current_in <= CUR_W'(low_current_level_in);
  wire                 loc_gate_run  = (low_current_mode_in == LOC_MODE_RUN) & operating_in;
  wire                 loc_gate_cst  = (low_current_mode_in == LOC_MODE_CONST) & operating_in
                                       & constant_speed_in;
  wire                 hw_trip       = (trip_code_in == TRIP_CT) | (trip_code_in == TRIP_CPU) |
                                       (trip_code_in == TRIP_GND) | (trip_code_in == TRIP_FAN) |
                                       (trip_code_in == TRIP_GA_COMM) | (trip_code_in == TRIP_MAIN);
  logic [NUM_FLAGS-1:0] next_flags;

  always_comb begin
    next_flags           = '0;
    next_flags[FLAG_CMD] = command_present_in;
    next_flags[FLAG_OHF] = heatsink_temp_in > overheat_threshold_in;
    next_flags[FLAG_LOC] = low_current & (loc_gate_run | loc_gate_cst);
    next_flags[FLAG_RDY] = ready_in;
    next_flags[FLAG_FWR] = forward_drive_in;
    next_flags[FLAG_RVR] = reverse_drive_in;
    next_flags[FLAG_MJA] = trip_active_in & hw_trip;
  end

  // flags move only on the sampling tick, so every terminal sees one coherent snapshot
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      flags_out <= '0;
    end else if (sample_tick_in) begin
      flags_out <= next_flags;
    end
  end

endmodule

// ### hdl/dsos_term_sel.sv
`timescale 1ns/1ns
module dsos_term_sel (
  input  wire logic                           clk_in,
  input  wire logic                           rst_in,
  input  wire logic                           sample_tick_in,
  input  wire logic [dsos_pkg::NUM_FLAGS-1:0] flags_in,
  input  wire logic [7:0]                     select_in,
  output logic                                term_out
);
  import dsos_pkg::*;

  logic picked;

  // codes outside this block's set leave the terminal off
  always_comb begin
    unique case (select_in)
      CODE_CMD: picked = flags_in[FLAG_CMD];
      CODE_OHF: picked = flags_in[FLAG_OHF];
      CODE_LOC: picked = flags_in[FLAG_LOC];
      CODE_RDY: picked = flags_in[FLAG_RDY];
      CODE_FWR: picked = flags_in[FLAG_FWR];
      CODE_RVR: picked = flags_in[FLAG_RVR];
      CODE_MJA: picked = flags_in[FLAG_MJA];
      default:  picked = 1'b0;
    endcase
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      term_out <= 1'b0;
    end else if (sample_tick_in) begin
      term_out <= picked;
    end
  end

endmodule

// ### hdl/dsos_status_out.sv
// How it works
// - The command-present flag is high while any run command is received, whatever source feeds it; code 41.
// - Forward and reverse run commands active together stop the motor.
// - The overheat flag is high while heat-sink temperature is above the threshold; code 42.
// - The overheat threshold is settable from 0 to 200 degrees Celsius.
// - The low-current flag is high while output current is at or below the detection level; code 43.
// - Low-current mode 00 allows the flag whenever the drive runs, mode 01 only at constant speed.
// - The low-current level is settable from 0.00 to 1.50 times rated current.
// - The drive-ready flag is high while a run command can be accepted; code 50.
// - A run command that arrives while not ready is ignored; only commands presented while ready act.
// - Without main power the drive-ready flag stays low even with control power present.
// - The forward flag is high while driving forward and low in reverse or stopped.
// - The reverse flag is high while driving in reverse and low forward or stopped; code 52.
// - A hardware trip of the listed kinds raises the major-failure flag beside the alarm; code 53.
// - Each of five output terminals and the relay has its own selection code picking its flag.
`timescale 1ns/1ns
module dsos_status_out #(
  parameter int unsigned SAMPLE_CYCLES = dsos_pkg::SAMPLE_CYCLES
) (
  input  wire logic                          clk_in,
  input  wire logic                          rst_in,
  input  wire logic [7:0]                    avs_address_in,
  input  wire logic                          avs_read_in,
  input  wire logic                          avs_write_in,
  input  wire logic [31:0]                   avs_writedata_in,
  input  wire logic [3:0]                    avs_byteenable_in,
  output logic      [31:0]                   avs_readdata_out,
  output logic                               avs_waitrequest_out,
  input  wire logic                          forward_run_command_in,
  input  wire logic                          reverse_run_command_in,
  input  wire logic                          main_power_ok_in,
  input  wire logic                          trip_active_in,
  input  wire logic [7:0]                    trip_code_in,
  input  wire logic [7:0]                    heatsink_temp_in,
  input  wire logic [dsos_pkg::CUR_W-1:0]    output_current_in,
  input  wire logic                          constant_speed_in,
  output logic                               run_forward_out,
  output logic                               run_reverse_out,
  output logic      [dsos_pkg::NUM_TERM-2:0] output_terminal_out,
  output logic                               relay_out,
  output logic                               irq_out
);
  import dsos_pkg::*;

  localparam int unsigned SEL_W = 3;

  // sampling tick
  logic [15:0]          tick_count;
  logic                 sample_tick;

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      tick_count  <= '0;
      sample_tick <= 1'b0;
    end else if (tick_count == 16'(SAMPLE_CYCLES - 1)) begin
      tick_count  <= '0;
      sample_tick <= 1'b1;
    end else begin
      tick_count  <= tick_count + 16'h0001;
      sample_tick <= 1'b0;
    end
  end

  // run command acceptance
  dsos_run_state_t      run_state;
  dsos_run_state_t      next_run_state;
  logic                 fwd_cmd_q;
  logic                 rev_cmd_q;

  wire                  drive_ready = main_power_ok_in & ~trip_active_in;
  wire                  both_cmds   = forward_run_command_in & reverse_run_command_in;
  wire                  fwd_new     = forward_run_command_in & ~fwd_cmd_q;
  wire                  rev_new     = reverse_run_command_in & ~rev_cmd_q;
  wire                  any_cmd     = forward_run_command_in | reverse_run_command_in;

  // only a command edge seen while ready starts the drive, so a command held
  // through a not-ready period must be re-issued
  always_comb begin
    next_run_state = run_state;
    unique case (run_state)
      RUN_STOP: begin
        if (drive_ready && !both_cmds && fwd_new) begin
          next_run_state = RUN_FWD;
        end else if (drive_ready && !both_cmds && rev_new) begin
          next_run_state = RUN_REV;
        end
      end
      RUN_FWD: begin
        if (!forward_run_command_in || both_cmds || !drive_ready) begin
          next_run_state = RUN_STOP;
        end
      end
      RUN_REV: begin
        if (!reverse_run_command_in || both_cmds || !drive_ready) begin
          next_run_state = RUN_STOP;
        end
      end
    endcase
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      run_state       <= RUN_STOP;
      fwd_cmd_q       <= 1'b0;
      rev_cmd_q       <= 1'b0;
      run_forward_out <= 1'b0;
      run_reverse_out <= 1'b0;
    end else begin
      run_state       <= next_run_state;
      fwd_cmd_q       <= forward_run_command_in;
      rev_cmd_q       <= reverse_run_command_in;
      run_forward_out <= next_run_state == RUN_FWD;
      run_reverse_out <= next_run_state == RUN_REV;
    end
  end

  // settings
  logic [7:0]           overheat_threshold_setting;
  logic [1:0]           low_current_mode_setting;
  logic [7:0]           low_current_level_setting;
  logic [7:0]           term_select [NUM_TERM];
  logic [NUM_FLAGS-1:0] irq_status;
  logic [NUM_FLAGS-1:0] irq_mask;

  // bus decode: one wait cycle, then the transfer completes
  wire                  bus_req     = avs_read_in | avs_write_in;
  wire                  bus_accept  = bus_req & ~avs_waitrequest_out;
  wire                  wr_en       = bus_accept & avs_write_in & avs_byteenable_in[0];
  wire [7:0]            wdata       = avs_writedata_in[7:0];
  wire                  aligned     = avs_address_in[1:0] == 2'h0;
  wire                  hit_thresh  = aligned & (avs_address_in == OFF_OHF_THRESH);
  wire                  hit_mode    = aligned & (avs_address_in == OFF_LOC_MODE);
  wire                  hit_level   = aligned & (avs_address_in == OFF_LOC_LEVEL);
  wire                  hit_flags   = aligned & (avs_address_in == OFF_FLAGS);
  wire                  hit_status  = aligned & (avs_address_in == OFF_IRQ_STATUS);
  wire                  hit_mask    = aligned & (avs_address_in == OFF_IRQ_MASK);
  wire                  hit_run     = aligned & (avs_address_in == OFF_RUN_STATE);
  wire [7:0]            sel_off     = avs_address_in - OFF_TERM_SEL0;
  wire                  hit_sel     = aligned & (avs_address_in >= OFF_TERM_SEL0) & (sel_off < OFF_SEL_SPAN);
  wire [SEL_W-1:0]      sel_index   = sel_off[SEL_W+1:2];

  // out-of-range threshold and level writes saturate to the top of the range; out-of-range mode writes are ignored
  wire [7:0]            thresh_wr   = (wdata > OHF_THRESH_MAX) ? OHF_THRESH_MAX : wdata;
  wire [7:0]            level_wr    = (wdata > LOC_LEVEL_MAX) ? LOC_LEVEL_MAX : wdata;
  wire                  mode_ok     = (wdata[1:0] == LOC_MODE_RUN) | (wdata[1:0] == LOC_MODE_CONST);
  wire                  mode_wr     = wr_en & hit_mode & mode_ok & (wdata[7:2] == 6'h00);

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      overheat_threshold_setting <= RST_OHF_THRESH;
      low_current_mode_setting   <= LOC_MODE_RUN;
      low_current_level_setting  <= RST_LOC_LEVEL;
      irq_mask                   <= '0;
    end else begin
      if (wr_en && hit_thresh) begin
        overheat_threshold_setting <= thresh_wr;
      end
      if (mode_wr) begin
        low_current_mode_setting <= wdata[1:0];
      end
      if (wr_en && hit_level) begin
        low_current_level_setting <= level_wr;
      end
      if (wr_en && hit_mask) begin
        irq_mask <= wdata[NUM_FLAGS-1:0];
      end
    end
  end

  // one selection register per terminal, relay last
  localparam logic [7:0] SEL_RST [NUM_TERM] = '{RST_SEL_TERM0, RST_SEL_TERM1, RST_SEL_TERM2,
                                                RST_SEL_TERM3, RST_SEL_TERM4, RST_SEL_RELAY};
  logic [NUM_FLAGS-1:0] flags;
  logic [NUM_TERM-1:0]  term_bits;

  genvar gi;
  generate
    for (gi = 0; gi < NUM_TERM; gi++) begin : g_term
      always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
          term_select[gi] <= SEL_RST[gi];
        end else if (wr_en && hit_sel && (sel_index == SEL_W'(gi))) begin
          term_select[gi] <= wdata;
        end
      end

      dsos_term_sel u_term_sel (
        .clk_in         (clk_in),
        .rst_in         (rst_in),
        .sample_tick_in (sample_tick),
        .flags_in       (flags),
        .select_in      (term_select[gi]),
        .term_out       (term_bits[gi])
      );
    end
  endgenerate

  assign output_terminal_out = term_bits[NUM_TERM-2:0];
  assign relay_out           = term_bits[NUM_TERM-1];

  dsos_flag_eval u_flag_eval (
    .clk_in                (clk_in),
    .rst_in                (rst_in),
    .sample_tick_in        (sample_tick),
    .command_present_in    (any_cmd),
    .heatsink_temp_in      (heatsink_temp_in),
    .overheat_threshold_in (overheat_threshold_setting),
    .output_current_in     (output_current_in),
    .low_current_level_in  (low_current_level_setting),
    .low_current_mode_in   (low_current_mode_setting),
    .operating_in          (run_state != RUN_STOP),
    .constant_speed_in     (constant_speed_in),
    .ready_in              (drive_ready),
    .forward_drive_in      (run_state == RUN_FWD),
    .reverse_drive_in      (run_state == RUN_REV),
    .trip_active_in        (trip_active_in),
    .trip_code_in          (trip_code_in),
    .flags_out             (flags)
  );

  // interrupts: a rising flag sets its sticky bit; a new event beats a same-cycle clear
  logic [NUM_FLAGS-1:0] flags_q;
  wire  [NUM_FLAGS-1:0] flag_rise   = flags & ~flags_q;
  wire  [NUM_FLAGS-1:0] status_clr  = (wr_en && hit_status) ? wdata[NUM_FLAGS-1:0] : '0;
  wire  [NUM_FLAGS-1:0] next_status = (irq_status & ~status_clr) | flag_rise;

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      flags_q    <= '0;
      irq_status <= '0;
      irq_out    <= 1'b0;
    end else begin
      flags_q    <= flags;
      irq_status <= next_status;
      irq_out    <= |(next_status & irq_mask);
    end
  end

  // read path
  wire [31:0] read_word =
    hit_thresh ? {24'h0, overheat_threshold_setting} :
    hit_mode   ? {30'h0, low_current_mode_setting} :
    hit_level  ? {24'h0, low_current_level_setting} :
    hit_sel    ? {24'h0, term_select[sel_index]} :
    hit_flags  ? {25'h0, flags} :
    hit_status ? {25'h0, irq_status} :
    hit_mask   ? {25'h0, irq_mask} :
    hit_run    ? {29'h0, drive_ready, run_state == RUN_REV, run_state == RUN_FWD} :
                 32'h00000000;

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      avs_waitrequest_out <= 1'b1;
      avs_readdata_out    <= '0;
    end else begin
      avs_waitrequest_out <= ~(bus_req & avs_waitrequest_out);
      if (bus_req && avs_waitrequest_out) begin
        avs_readdata_out <= avs_read_in ? read_word : 32'h00000000;
      end
    end
  end

endmodule

// ### verif/dsos_status_out_chk.sv
`timescale 1ns/1ns
module dsos_status_out_chk
  import dsos_pkg::*;
#(
  parameter int unsigned SAMPLE_CYCLES = dsos_pkg::SAMPLE_CYCLES
) (
  input wire logic                           clk_in,
  input wire logic                           rst_in,
  input wire logic                           avs_read_in,
  input wire logic                           avs_write_in,
  input wire logic                           avs_waitrequest_out,
  input wire logic                           forward_run_command_in,
  input wire logic                           reverse_run_command_in,
  input wire logic                           main_power_ok_in,
  input wire logic                           trip_active_in,
  input wire logic                           run_forward_out,
  input wire logic                           run_reverse_out,
  input wire logic [dsos_pkg::NUM_TERM-2:0]  output_terminal_out,
  input wire logic                           relay_out
);
  logic [15:0] gap;
  logic [5:0]  outs;
  assign outs = {relay_out, output_terminal_out};
  // cycles since the terminals last moved; saturates so it never wraps
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      gap <= 16'h0;
    end else if ($changed(outs)) begin
      gap <= 16'h1;
    end else if (gap != 16'hffff) begin
      gap <= gap + 16'h1;
    end
  end
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (rst_in);
  property p_both_stop;
    forward_run_command_in && reverse_run_command_in |=> !run_forward_out && !run_reverse_out;
  endproperty
  a_both_stop: assert property (p_both_stop)
    else $error("drive kept running with both commands");
  property p_idle_stop;
    !forward_run_command_in && !reverse_run_command_in |=> !run_forward_out && !run_reverse_out;
  endproperty
  a_idle_stop: assert property (p_idle_stop)
    else $error("drive kept running without command");
  property p_one_dir;
    run_forward_out |-> !run_reverse_out;
  endproperty
  a_one_dir: assert property (p_one_dir)
    else $error("both directions driven");
  property p_fwd_start;
    $rose(run_forward_out) |-> $past(forward_run_command_in) && !$past(reverse_run_command_in)
      && $past(main_power_ok_in) && !$past(trip_active_in);
  endproperty
  a_fwd_start: assert property (p_fwd_start)
    else $error("forward drive started without accepted command");
  property p_rev_start;
    $rose(run_reverse_out) |-> $past(reverse_run_command_in) && !$past(forward_run_command_in)
      && $past(main_power_ok_in) && !$past(trip_active_in);
  endproperty
  a_rev_start: assert property (p_rev_start)
    else $error("reverse drive started without accepted command");
  property p_term_gap;
    $changed(outs) |-> gap >= SAMPLE_CYCLES;
  endproperty
  a_term_gap: assert property (p_term_gap)
    else $error("terminals moved between sample ticks");
  property p_wait_one;
    (avs_read_in || avs_write_in) && avs_waitrequest_out |=> !avs_waitrequest_out;
  endproperty
  a_wait_one: assert property (p_wait_one)
    else $error("bus answer not after one wait state");
  property p_wait_back;
    !avs_waitrequest_out |=> avs_waitrequest_out;
  endproperty
  a_wait_back: assert property (p_wait_back)
    else $error("waitrequest low for more than one cycle");
endmodule
bind dsos_status_out dsos_status_out_chk #(.SAMPLE_CYCLES(SAMPLE_CYCLES)) u_chk (
  .clk_in(clk_in), .rst_in(rst_in), .avs_read_in(avs_read_in), .avs_write_in(avs_write_in),
  .avs_waitrequest_out(avs_waitrequest_out), .forward_run_command_in(forward_run_command_in),
  .reverse_run_command_in(reverse_run_command_in), .main_power_ok_in(main_power_ok_in),
  .trip_active_in(trip_active_in), .run_forward_out(run_forward_out), .run_reverse_out(run_reverse_out),
  .output_terminal_out(output_terminal_out), .relay_out(relay_out)
);

// ### verif/dsos_term_monitor.sv
`timescale 1ns/1ns
module dsos_term_monitor (
  input  wire logic       clk_in,
  input  wire logic       rst_in,
  input  wire logic [4:0] terminal_in,
  input  wire logic       relay_in,
  output logic      [5:0] seen_out
);
  // equipment latches the lines each clock, so it sees only settled levels
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      seen_out <= 6'h0;
    end else begin
      seen_out <= {relay_in, terminal_in};
    end
  end
endmodule

// ### verif/dsos_status_out_tb.sv
`timescale 1ns/1ns
module dsos_status_out_tb;
  import dsos_pkg::*;
  localparam int unsigned SC = 4;
  logic        clk_in;
  logic        rst_in;
  logic [7:0]  adr;
  logic        rd_en;
  logic        wr_en;
  logic [31:0] wdat;
  logic [3:0]  ben;
  logic [31:0] rdat;
  logic        waitreq;
  logic        fwd;
  logic        rev;
  logic        pwr;
  logic        trip;
  logic [7:0]  tcode;
  logic [7:0]  temp;
  logic [9:0]  cur;
  logic        cspd;
  logic        run_f;
  logic        run_r;
  logic [4:0]  term;
  logic        relay;
  logic        irq;
  logic [5:0]  seen;
  logic [31:0] rd;
  int          fail_count;
  int          total_checks;
  logic [7:0]  hw_trips [6] = '{TRIP_CT, TRIP_CPU, TRIP_GND, TRIP_FAN, TRIP_GA_COMM, TRIP_MAIN};
  logic [7:0]  sel_rst [6] = '{RST_SEL_TERM0, RST_SEL_TERM1, RST_SEL_TERM2, RST_SEL_TERM3, RST_SEL_TERM4,
                               RST_SEL_RELAY};
  initial begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end
  dsos_status_out #(.SAMPLE_CYCLES(SC)) dut (
    .clk_in(clk_in), .rst_in(rst_in), .avs_address_in(adr), .avs_read_in(rd_en), .avs_write_in(wr_en),
    .avs_writedata_in(wdat), .avs_byteenable_in(ben), .avs_readdata_out(rdat), .avs_waitrequest_out(waitreq),
    .forward_run_command_in(fwd), .reverse_run_command_in(rev), .main_power_ok_in(pwr),
    .trip_active_in(trip), .trip_code_in(tcode), .heatsink_temp_in(temp), .output_current_in(cur),
    .constant_speed_in(cspd), .run_forward_out(run_f), .run_reverse_out(run_r),
    .output_terminal_out(term), .relay_out(relay), .irq_out(irq)
  );
  dsos_term_monitor mon (.clk_in(clk_in), .rst_in(rst_in), .terminal_in(term), .relay_in(relay), .seen_out(seen));
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    adr <= a;
    wdat <= d;
    wr_en <= wr;
    rd_en <= !wr;
    @(posedge clk_in);
    while (waitreq !== 1'b0 && n < 50) begin
      @(posedge clk_in);
      n++;
    end
    if (n == 50) fail_count++;
    rd = rdat;
    rd_en <= 1'b0;
    wr_en <= 1'b0;
    @(posedge clk_in);
  endtask
  task automatic check(input string nm, input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    check(nm, rd, exp);
  endtask
  task automatic flag(input string nm, input int b, input logic exp);
    bus(1'b0, OFF_FLAGS, 32'h0);
    check(nm, 32'(rd[b]), 32'(exp));
  endtask
  // flag on one tick, terminal on the next, monitor one clock later
  task automatic settle();
    repeat (3 * SC + 4) @(posedge clk_in);
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  initial begin
    #200000;
    fail_count++;
    stop_test();
  end
  initial begin
    fail_count = 0;
    total_checks = 0;
    rst_in = 1'b1;
    ben = 4'hf;
    {adr, rd_en, wr_en, wdat, fwd, rev, pwr, trip, tcode, temp, cur, cspd} = '0;
    repeat (12) @(posedge clk_in);
    rst_in <= 1'b0;
    @(posedge clk_in);
    rchk("threshold", OFF_OHF_THRESH, {24'h0, RST_OHF_THRESH});
    rchk("mode", OFF_LOC_MODE, 32'h0);
    rchk("level", OFF_LOC_LEVEL, 32'h0);
    for (int i = 0; i < 6; i++) begin
      rchk("select", OFF_TERM_SEL0 + 8'(4 * i), {24'h0, sel_rst[i]});
    end
    rchk("unmapped", 8'h40, 32'h0);
    $display("test reset done");
    fwd <= 1'b1;
    settle();
    check("fwd without power", 32'(run_f), 32'h0);
    flag("cmd flag", FLAG_CMD, 1'b1);
    flag("ready no power", FLAG_RDY, 1'b0);
    pwr <= 1'b1;
    settle();
    check("held command", 32'(run_f), 32'h0);
    flag("ready", FLAG_RDY, 1'b1);
    check("ready terminal", 32'(seen[3]), 32'h1);
    fwd <= 1'b0;
    @(posedge clk_in);
    fwd <= 1'b1;
    settle();
    check("fwd run", 32'(run_f), 32'h1);
    flag("fwd flag", FLAG_FWR, 1'b1);
    check("fwd terminal", 32'({seen[4], seen[0]}), 32'h3);
    rev <= 1'b1;
    settle();
    check("both stop", 32'({run_f, run_r}), 32'h0);
    flag("fwd flag stop", FLAG_FWR, 1'b0);
    fwd <= 1'b0;
    rev <= 1'b0;
    @(posedge clk_in);
    rev <= 1'b1;
    bus(1'b1, OFF_TERM_SEL0, {24'h0, CODE_RVR});
    settle();
    check("rev run", 32'({run_f, run_r}), 32'h1);
    check("rev terminal", 32'(seen[0]), 32'h1);
    $display("test drive done");
    bus(1'b1, OFF_LOC_LEVEL, 32'h32);
    cur <= 10'h32;
    settle();
    flag("low at level", FLAG_LOC, 1'b1);
    cur <= 10'h33;
    settle();
    flag("low above", FLAG_LOC, 1'b0);
    bus(1'b1, OFF_LOC_MODE, 32'h1);
    cur <= 10'h32;
    settle();
    flag("low not const", FLAG_LOC, 1'b0);
    cspd <= 1'b1;
    settle();
    flag("low const", FLAG_LOC, 1'b1);
    check("low terminal", 32'(seen[2]), 32'h1);
    bus(1'b1, OFF_LOC_MODE, 32'h2);
    rchk("mode kept", OFF_LOC_MODE, 32'h1);
    bus(1'b1, OFF_LOC_LEVEL, 32'hff);
    rchk("level max", OFF_LOC_LEVEL, {24'h0, LOC_LEVEL_MAX});
    rev <= 1'b0;
    settle();
    flag("rev flag stop", FLAG_RVR, 1'b0);
    bus(1'b1, OFF_OHF_THRESH, 32'h50);
    temp <= 8'h50;
    settle();
    flag("heat at level", FLAG_OHF, 1'b0);
    temp <= 8'h51;
    settle();
    flag("heat above", FLAG_OHF, 1'b1);
    check("heat terminal", 32'(seen[1]), 32'h1);
    bus(1'b1, OFF_OHF_THRESH, 32'hff);
    rchk("threshold max", OFF_OHF_THRESH, {24'h0, OHF_THRESH_MAX});
    $display("test levels done");
    // mask still clear: a major failure must stay silent until unmasked
    bus(1'b1, OFF_IRQ_STATUS, 32'h7f);
    trip <= 1'b1;
    tcode <= TRIP_CT;
    settle();
    check("irq masked", 32'(irq), 32'h0);
    trip <= 1'b0;
    bus(1'b1, OFF_IRQ_MASK, 32'h40);
    repeat (2) @(posedge clk_in);
    check("irq sticky", 32'(irq), 32'h1);
    for (int i = 0; i < 7; i++) begin
      bus(1'b1, OFF_IRQ_STATUS, 32'h7f);
      repeat (2) @(posedge clk_in);
      check("irq clear", 32'(irq), 32'h0);
      trip <= 1'b1;
      tcode <= (i < 6) ? hw_trips[i] : 8'h0c;
      settle();
      flag("major", FLAG_MJA, i < 6);
      check("relay", 32'(seen[5]), 32'(i < 6));
      check("irq major", 32'(irq), 32'(i < 6));
      trip <= 1'b0;
      settle();
    end
    $display("test failure done");
    stop_test();
  end
endmodule
